/* File: src/faacu_unit.sv */
// FP abs/add/compare unit with its register file, APB slave and interrupt logic
// What this block does
// - Absolute value clears bit 31 of the selected register, keeps the rest, in one state.
// - Absolute value leaves cause and flag untouched and never raises an exception.
// - With single precision selected, add sums two single registers in one state.
// - With double precision selected, add sums two register pairs in six states.
// - Any of the overflow, underflow or inexact enables makes every add trap.
// - A trapping add records cause and flag and leaves the destination unchanged.
// - Add clears the cause first and a signalling NaN operand signals invalid above all.
// - Otherwise a quiet NaN operand gives a quiet NaN result in the destination.
// - Otherwise a denormal operand raises the FPU error instead of a sum.
// - Positive zero source plus negative zero destination writes positive zero.
// - With denormal flush set, add and compare see every denormal as a signed zero.
// - Equality compare sets the test flag on equal operands, else clears it, in one state.
// - Greater compare sets the test flag only if destination exceeds source, in two states.
// - A quiet NaN operand gives an unordered outcome, which clears the test flag.
// - Positive and negative zero compare equal.
// - Two positive infinities are equal and positive infinity beats a finite normal.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
module faacu_unit import faacu_pkg::*; (
   // Clock, reset, enable
   input  logic       pclk,
   input  logic       presetn,
   input  logic       ce,
   // APB slave
   input  faacu_apb_t apb,
   output faacu_rsp_t rsp,
   // Core side
   output logic       t_bit,
   output logic       busy,
   output logic       irq
);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn || !ce);

   function automatic faacu_cls_t fcls(input logic [63:0] x, input logic d);
      logic sg, ez, em, fz, fm;
      sg = d ? x[D_SGN] : x[S_SGN];
      ez = d ? ~|x[D_EXP_HI:D_EXP_LO] : ~|x[S_EXP_HI:S_EXP_LO];
      em = d ? &x[D_EXP_HI:D_EXP_LO] : &x[S_EXP_HI:S_EXP_LO];
      fz = d ? ~|x[D_EXP_LO-1:0] : ~|x[S_EXP_LO-1:0];
      fm = d ? x[D_EXP_LO-1] : x[S_EXP_LO-1];
      if (ez)
         return fz ? (sg ? C_NZ : C_PZ) : C_DN;
      else if (!em)
         return C_NM;
      else if (fz)
         return sg ? C_NI : C_PI;
      // Quiet bit is inverted here: a set top fraction bit marks signalling
      return fm ? C_SN : C_QN;
   endfunction

   function automatic logic [63:0] sgnz(input logic d, input logic s);
      return d ? {s, 63'h0} : {32'h0, s, 31'h0};
   endfunction

   function automatic logic [63:0] canon(input logic [63:0] x, input logic d,
                                         input logic f);
      if (f && fcls(x, d) == C_DN)
         return sgnz(d, d ? x[D_SGN] : x[S_SGN]);
      return x;
   endfunction

   // Ordered key: unsigned compare of keys matches numeric order
   function automatic logic [63:0] okey(input logic [63:0] x, input logic d);
      logic [63:0] y;
      y = d ? x : {x[31:0], 32'h0};
      return y[63] ? ~y : {1'b1, y[62:0]};
   endfunction

   // Normal plus normal, round to nearest even; returns {sum, ovf, unf, inx}
   function automatic logic [66:0] fp_add_op(input logic [63:0] a, input logic [63:0] b,
                                        input logic d);
      logic        sa, sb, g, st, fnd;
      logic [12:0] ea, eb, ex, er;
      logic [55:0] ma, mb, mt, msk;
      logic [56:0] sm;
      logic [5:0]  lz;
      int          p;
      sa = d ? a[D_SGN] : a[S_SGN];
      sb = d ? b[D_SGN] : b[S_SGN];
      ea = d ? 13'(a[D_EXP_HI:D_EXP_LO]) : 13'(a[S_EXP_HI:S_EXP_LO]);
      eb = d ? 13'(b[D_EXP_HI:D_EXP_LO]) : 13'(b[S_EXP_HI:S_EXP_LO]);
      ma = d ? {1'b1, a[D_EXP_LO-1:0], 3'h0} : {1'b1, a[S_EXP_LO-1:0], 32'h0};
      mb = d ? {1'b1, b[D_EXP_LO-1:0], 3'h0} : {1'b1, b[S_EXP_LO-1:0], 32'h0};
      if ({eb, mb} > {ea, ma}) begin
         {ea, ma, sa, eb, mb, sb} = {eb, mb, sb, ea, ma, sa};
      end
      ex = ea - eb;
      if (ex > 13'h0037) begin
         mt = {55'h0, |mb};
      end else begin
         msk = ~({56{1'b1}} << ex);
         mt = (mb >> ex) | {55'h0, |(mb & msk)};
      end
      sm = (sa == sb) ? {1'b0, ma} + {1'b0, mt} : {1'b0, ma} - {1'b0, mt};
      er = ea;
      if (sm[56]) begin
         sm = {1'b0, sm[56:2], sm[1] | sm[0]};
         er = er + 13'h0001;
      end
      lz = 6'h00;
      fnd = 1'b0;
      for (int i = 55; i >= 0; i--) begin
         if (!fnd && sm[i])
            fnd = 1'b1;
         else if (!fnd)
            lz = lz + 6'h01;
      end
      // Exact cancellation gives positive zero
      if (!fnd)
         return 67'h0;
      sm = sm << lz;
      er = er - 13'(lz);
      p = d ? RND_D : RND_S;
      msk = (56'h1 << (p - 1)) - 56'h1;
      g = sm[p-1];
      st = |(sm[55:0] & msk);
      if (g && (st || sm[p]))
         sm = sm + (57'h1 << p);
      if (sm[56]) begin
         sm = sm >> 1;
         er = er + 13'h0001;
      end
      if (!er[12] && er >= (d ? EMAX_D : EMAX_S))
         return {(d ? INF_D : INF_S) | sgnz(d, sa), 3'b101};
      // Tiny results flush to a signed zero rather than a denormal
      if (er[12] || er == 13'h0000)
         return {sgnz(d, sa), 3'b011};
      if (d)
         return {sa, er[10:0], sm[54:3], 2'b00, g | st};
      return {32'h0, sa, er[7:0], sm[54:32], 2'b00, g | st};
   endfunction

   function automatic faacu_kind_t decode(input logic [15:0] o, input logic pr);
      if (o[15:12] != OP_HI)
         return K_ILL;
      // Double form needs an even register number
      if (o[7:0] == OP_ABS_LO)
         return (pr && o[8]) ? K_ILL : K_ABS;
      if (pr && (o[8] || o[4]))
         return K_ILL;
      case (o[3:0])
         FN_ADD:  return K_ADD;
         FN_EQ:   return K_EQ;
         FN_GT:   return K_GT;
         default: return K_ILL;
      endcase
   endfunction

   faacu_state_t s;
   faacu_state_t nx;
   logic [3:0]   ni;
   logic [3:0]   mi;
   logic [3:0]   ne;
   logic [3:0]   me;
   logic [63:0]  opn;
   logic [63:0]  opm;
   logic [63:0]  res;
   logic [63:0]  qn;
   logic [66:0]  sum;
   faacu_cls_t   cn;
   faacu_cls_t   cm;
   logic [5:0]   cause;
   logic         wr;
   logic         trap;
   logic         unord;
   logic         eq;
   logic         gt;
   logic         fin;
   logic         setup;
   logic         acc;
   logic [2:0]   ev;
   logic [2:0]   clr;
   logic [2:0]   lat;
   faacu_kind_t  kd;
   logic [31:0]  abs_word;

   assign ni = s.op[11:8];
   assign mi = s.op[7:4];
   assign ne = {ni[3:1], 1'b0};
   assign me = {mi[3:1], 1'b0};
   assign fin = s.busy && s.cnt == 3'h0;
   assign qn = s.dbl ? QNAN_D : QNAN_S;
   assign abs_word = s.fr[ni];

   // Datapath of the operation in flight
   always_comb begin
      opn = canon(s.dbl ? {s.fr[ne], s.fr[ne + 4'h1]} : {32'h0, s.fr[ni]},
                  s.dbl, s.sc.denormal_flush);
      opm = canon(s.dbl ? {s.fr[me], s.fr[me + 4'h1]} : {32'h0, s.fr[mi]},
                  s.dbl, s.sc.denormal_flush);
      cn = fcls(opn, s.dbl);
      cm = fcls(opm, s.dbl);
      sum = fp_add_op(opn, opm, s.dbl);
      res = opn;
      wr = 1'b0;
      cause = 6'h00;
      unord = 1'b0;
      eq = 1'b0;
      gt = 1'b0;
      if (cn == C_SN || cm == C_SN) begin
         cause[CB_V] = 1'b1;
         res = qn;
         wr = 1'b1;
      end else if (cn == C_QN || cm == C_QN) begin
         res = qn;
         wr = 1'b1;
         unord = 1'b1;
      end else if (s.kind != K_ADD) begin
         case (cm)
            C_NM: begin
               gt = cn == C_PI || (cn != C_NI && okey(opn, s.dbl) > okey(opm, s.dbl));
               eq = cn == C_NM && opn == opm;
            end
            C_PZ, C_NZ: begin
               eq = cn == C_PZ || cn == C_NZ || opn == opm;
               gt = !eq && okey(opn, s.dbl) > okey(opm, s.dbl);
            end
            C_PI: eq = cn == C_PI;
            C_NI: begin
               eq = cn == C_NI;
               gt = cn != C_NI;
            end
            default: begin
               eq = opn == opm;
               gt = okey(opn, s.dbl) > okey(opm, s.dbl);
            end
         endcase
      end else if (cn == C_DN || cm == C_DN) begin
         cause[CB_E] = 1'b1;
      end else begin
         case (cm)
            C_NM: begin
               if (cn == C_NM) begin
                  res = sum[66:3];
                  cause[CB_O:CB_I] = sum[2:0];
                  wr = 1'b1;
               end else if (cn == C_PZ || cn == C_NZ) begin
                  res = opm;
                  wr = 1'b1;
               end
            end
            C_PZ: begin
               res = sgnz(s.dbl, 1'b0);
               wr = cn == C_NZ;
            end
            C_PI, C_NI: begin
               cause[CB_V] = (cn == C_PI || cn == C_NI) && cn != cm;
               res = cause[CB_V] ? qn : (s.dbl ? INF_D : INF_S) | sgnz(s.dbl, cm == C_NI);
               wr = 1'b1;
            end
            default: wr = 1'b0;
         endcase
      end
      trap = cause[CB_E] || (cause[CB_V] && s.sc.enable[CB_V]) ||
             (s.kind == K_ADD && |s.sc.enable[CB_O:CB_I]);
   end

   // Next state: bus slave, issue, completion, interrupts
   always_comb begin
      nx = s;
      ev = 3'h0;
      clr = 3'h0;
      setup = apb.psel && !apb.penable;
      acc = apb.psel && apb.penable && s.rsp.pready;
      kd = decode(apb.pwdata[15:0], s.sc.precision_select);
      case (kd)
         K_ABS:   lat = LAT_ABS;
         K_ADD:   lat = s.sc.precision_select ? LAT_ADD_D : LAT_ADD_S;
         K_EQ:    lat = LAT_EQ;
         K_GT:    lat = LAT_GT;
         default: lat = LAT_ABS;
      endcase
      nx.rsp.pready = 1'b0;
      if (setup) begin
         nx.rsp.pready = 1'b1;
         nx.rsp.prdata = 32'h0;
         // Operands must hold still while an operation is in flight
         nx.rsp.pslverr = apb.pwrite && s.busy;
         if (apb.paddr[1:0] != 2'h0) begin
            nx.rsp.pslverr = 1'b1;
         end else if (apb.paddr[7:6] == A_FRPG) begin
            nx.rsp.prdata = s.fr[apb.paddr[5:2]];
         end else begin
            case (apb.paddr)
               A_CTRL:  nx.rsp.prdata = {{(32-SC_W){1'b0}}, s.sc};
               A_CMD:   nx.rsp.prdata = {s.op, 14'h0, s.t, s.busy};
               A_IST:   nx.rsp.prdata = {29'h0, s.ist};
               A_ICLR:  nx.rsp.pslverr = 1'b0;
               A_IEN:   nx.rsp.prdata = {29'h0, s.ien};
               default: nx.rsp.pslverr = 1'b1;
            endcase
         end
      end
      if (fin) begin
         nx.busy = 1'b0;
         nx.st = ST_IDLE;
         ev[IRQ_DONE] = 1'b1;
         if (s.kind == K_ABS) begin
            nx.fr[ni] = s.fr[ni] & SIGN_CLR;
         end else begin
            nx.sc.cause = cause;
            nx.sc.flag = s.sc.flag | cause[CB_V:CB_I];
            ev[IRQ_TRAP] = trap;
            if (s.kind == K_ADD && wr && !trap && s.dbl) begin
               nx.fr[ne] = res[63:32];
               nx.fr[ne + 4'h1] = res[31:0];
            end else if (s.kind == K_ADD && wr && !trap) begin
               nx.fr[ni] = res[31:0];
            end
            if (s.kind != K_ADD)
               nx.t = (s.kind == K_EQ) ? eq : gt;
         end
      end else if (s.busy) begin
         nx.cnt = s.cnt - 3'h1;
      end
      if (acc && apb.pwrite && !s.rsp.pslverr) begin
         if (apb.paddr[7:6] == A_FRPG) begin
            nx.fr[apb.paddr[5:2]] = apb.pwdata;
         end else begin
            case (apb.paddr)
               A_CTRL: nx.sc = faacu_sc_t'(apb.pwdata[SC_W-1:0]);
               A_CMD: begin
                  nx.op = apb.pwdata[15:0];
                  ev[IRQ_ILL] = kd == K_ILL;
                  nx.busy = kd != K_ILL;
                  nx.st = (kd != K_ILL) ? ST_EXEC : ST_IDLE;
                  nx.kind = kd;
                  nx.dbl = s.sc.precision_select;
                  nx.cnt = lat - 3'h1;
               end
               A_ICLR:  clr = apb.pwdata[2:0];
               A_IEN:   nx.ien = apb.pwdata[2:0];
               default: nx.ien = s.ien;
            endcase
         end
      end
      // A new event in the clearing cycle survives
      nx.ist = (s.ist & ~clr) | ev;
      nx.irq = |(nx.ist & nx.ien);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.st <= ST_IDLE;
      end else if (ce) begin
         s <= nx;
      end
   end

   assign rsp = s.rsp;
   assign t_bit = s.t;
   assign busy = s.busy;
   assign irq = s.irq;

   a_abs_sign: assert property (fin && s.kind == K_ABS |=>
      s.fr[$past(ni)] == ($past(abs_word) & SIGN_CLR)) else $error("abs result wrong");
   a_abs_keep: assert property (fin && s.kind == K_ABS |=>
      s.sc == $past(s.sc) && (!s.ist[IRQ_TRAP] || $past(s.ist[IRQ_TRAP])))
      else $error("abs touched status");
   a_add_single: assert property ($rose(s.busy) && s.kind == K_ADD && !s.dbl
      |=> !s.busy) else $error("single add latency");
   a_add_double: assert property ($rose(s.busy) && s.kind == K_ADD && s.dbl
      |-> s.busy[*6] ##1 !s.busy) else $error("double add latency");
   a_trap_forced: assert property (fin && s.kind == K_ADD &&
      |s.sc.enable[CB_O:CB_I] |=> s.ist[IRQ_TRAP]) else $error("no forced trap");
   a_trap_keep: assert property (fin && s.kind == K_ADD && trap |=>
      s.fr == $past(s.fr)) else $error("destination written on trap");
   a_snan_inval: assert property (fin && s.kind == K_ADD &&
      (cn == C_SN || cm == C_SN) |=> s.sc.cause[CB_V]) else $error("snan not invalid");
   a_eq_lat: assert property ($rose(s.busy) && s.kind == K_EQ |=> !s.busy)
      else $error("equal latency");
   a_gt_lat: assert property ($rose(s.busy) && s.kind == K_GT |->
      s.busy[*2] ##1 !s.busy) else $error("greater latency");
   a_unord_false: assert property (fin && (s.kind == K_EQ || s.kind == K_GT) &&
      unord |=> !s.t) else $error("unordered set test flag");
   a_irq_level: assert property (s.irq == |(s.ist & s.ien)) else $error("irq mismatch");

   c_add_double: cover property ($rose(s.busy) && s.kind == K_ADD && s.dbl);
   c_gt_true: cover property (fin && s.kind == K_GT && gt);
   c_trap: cover property (fin && trap);
   c_illegal: cover property (ev[IRQ_ILL]);

endmodule

/* File: src/faacu_pkg.sv */
// Constants, types and state layout of the floating-point abs/add/compare unit
package faacu_pkg;

   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CMD  = 8'h04;
   localparam logic [7:0] A_IST  = 8'h08;
   localparam logic [7:0] A_ICLR = 8'h0c;
   localparam logic [7:0] A_IEN  = 8'h10;
   // paddr[7:6] of the FP register window 0x40..0x7c
   localparam logic [1:0] A_FRPG = 2'h1;

   // Cause bits; enable and flag use the low five
   localparam int CB_I = 0;
   localparam int CB_U = 1;
   localparam int CB_O = 2;
   localparam int CB_Z = 3;
   localparam int CB_V = 4;
   localparam int CB_E = 5;

   // Interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_TRAP = 1;
   localparam int IRQ_ILL  = 2;

   // Opcode fields
   localparam logic [3:0] OP_HI     = 4'hf;
   localparam logic [7:0] OP_ABS_LO = 8'h5d;
   localparam logic [3:0] FN_ADD    = 4'h0;
   localparam logic [3:0] FN_EQ     = 4'h4;
   localparam logic [3:0] FN_GT     = 4'h5;

   // Execution states per operation
   localparam logic [2:0] LAT_ABS   = 3'h1;
   localparam logic [2:0] LAT_ADD_S = 3'h1;
   localparam logic [2:0] LAT_ADD_D = 3'h6;
   localparam logic [2:0] LAT_EQ    = 3'h1;
   localparam logic [2:0] LAT_GT    = 3'h2;

   // Number formats
   localparam int D_SGN    = 63;
   localparam int D_EXP_HI = 62;
   localparam int D_EXP_LO = 52;
   localparam int S_SGN    = 31;
   localparam int S_EXP_HI = 30;
   localparam int S_EXP_LO = 23;
   localparam int RND_D    = 3;
   localparam int RND_S    = 32;
   localparam logic [12:0] EMAX_D   = 13'h07ff;
   localparam logic [12:0] EMAX_S   = 13'h00ff;
   localparam logic [31:0] SIGN_CLR = 32'h7fffffff;
   localparam logic [63:0] QNAN_S   = 64'h00000000_7fbfffff;
   localparam logic [63:0] QNAN_D   = 64'h7ff7ffff_ffffffff;
   localparam logic [63:0] INF_S    = 64'h00000000_7f800000;
   localparam logic [63:0] INF_D    = 64'h7ff00000_00000000;

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} faacu_st_t;
   typedef enum logic [2:0] {K_ABS = 3'h0, K_ADD = 3'h1, K_EQ = 3'h2, K_GT = 3'h3,
                             K_ILL = 3'h4} faacu_kind_t;
   typedef enum logic [2:0] {C_NM = 3'h0, C_PZ = 3'h1, C_NZ = 3'h2, C_DN = 3'h3,
                             C_PI = 3'h4, C_NI = 3'h5, C_QN = 3'h6, C_SN = 3'h7} faacu_cls_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } faacu_apb_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } faacu_rsp_t;

   typedef struct packed {
      logic       precision_select;
      logic       denormal_flush;
      logic [5:0] cause;
      logic [4:0] enable;
      logic [4:0] flag;
   } faacu_sc_t;
   localparam int SC_W = 18;

   typedef struct packed {
      faacu_st_t        st;
      logic             busy;
      logic [2:0]       cnt;
      logic [15:0]      op;
      faacu_kind_t      kind;
      logic             dbl;
      faacu_sc_t        sc;
      logic             t;
      logic [15:0][31:0] fr;
      logic [2:0]       ist;
      logic [2:0]       ien;
      faacu_rsp_t       rsp;
      logic             irq;
   } faacu_state_t;

endpackage

/* File: dv/faacu_host.sv */
// APB master model standing in for the instruction decode side
`timescale 1ns/1ps
module faacu_host import faacu_pkg::*; (
   // Clock
   input  logic       pclk,
   // APB master
   output faacu_apb_t apb,
   input  faacu_rsp_t rsp
);
   initial apb = '0;

   // Request held until pready is seen high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      apb.psel    <= 1'b1;
      apb.penable <= 1'b0;
      apb.pwrite  <= w;
      apb.paddr   <= a;
      apb.pwdata  <= d;
      @(posedge pclk);
      apb.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      e = rsp.pslverr;
      apb.psel    <= 1'b0;
      apb.penable <= 1'b0;
      // Idle lines carry no stale value a slave could lean on
      apb.paddr   <= ~a;
      apb.pwdata  <= ~d;
   endtask
endmodule

/* File: dv/faacu_unit_tb.sv */
// Self-checking bench for the FP abs/add/compare unit
`timescale 1ns/1ps
module faacu_unit_tb import faacu_pkg::*; ;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        ce      = 1'b1;
   faacu_apb_t  apb;
   faacu_rsp_t  rsp;
   logic        t_bit;
   logic        busy;
   logic        irq;
   int          failures = 0;
   int          total_checks = 0;
   logic [31:0] q;
   logic        e;

   always #50 pclk = ~pclk;

   faacu_unit u_faacu_unit (.pclk(pclk), .presetn(presetn), .ce(ce), .apb(apb),
      .rsp(rsp), .t_bit(t_bit), .busy(busy), .irq(irq));
   faacu_host u_faacu_host (.pclk(pclk), .apb(apb), .rsp(rsp));

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         failures++;
         $display("MISMATCH %s exp %h seen %h", nm, x, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_faacu_host.xfer(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      u_faacu_host.xfer(1'b0, a, 32'h0, q, e);
      chk($sformatf("read %h", a), q, x);
   endtask

   function automatic logic [7:0] fa(input int n);
      return 8'h40 + 8'(4 * n);
   endfunction

   // Busy is counted in whole cycles; a refused opcode never raises it
   task automatic op(input logic [15:0] c, input int l);
      int n;
      n = 0;
      wr(A_CMD, {16'h0, c});
      #1;
      while (busy === 1'b1 && n < 20) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk("busy cycles", 32'(n), 32'(l));
   endtask

   task automatic cmp(input logic [31:0] vn, input logic [31:0] vm, input logic gt,
                      input logic x);
      wr(fa(14), vn);
      wr(fa(15), vm);
      op({12'hfef, 3'b010, gt}, gt ? int'(LAT_GT) : int'(LAT_EQ));
      chk("t_bit", {31'h0, t_bit}, {31'h0, x});
   endtask

   task automatic wrap_up();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #2_000_000;
      failures++;
      wrap_up();
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_CTRL, 32'h0);
      rd(A_IST, 32'h0);
      rd(8'h20, 32'h0);
      chk("unmapped err", {31'h0, e}, 32'h1);
      wr(A_IEN, 32'h1);
      // Flags preset so a stray update shows
      wr(A_CTRL, 32'h1f);
      wr(fa(3), 32'hc0490fdb);
      op(16'hf35d, LAT_ABS);
      rd(fa(3), 32'h40490fdb);
      rd(A_CTRL, 32'h1f);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(A_IEN, 32'h0);
      rd(A_IST, 32'h1);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(A_ICLR, 32'h1);
      wr(A_IEN, 32'h1);
      rd(A_IST, 32'h0);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      wr(A_CTRL, 32'h20000);
      wr(fa(2), 32'hc0000000);
      wr(fa(3), 32'hffffffff);
      op(16'hf25d, LAT_ABS);
      rd(fa(2), 32'h40000000);
      rd(fa(3), 32'hffffffff);
      op(16'hf120, 0);
      rd(A_IST, 32'h5);
      wr(A_CTRL, 32'h0);
      wr(fa(0), 32'h3f800000);
      wr(fa(1), 32'h40000000);
      op(16'hf010, LAT_ADD_S);
      rd(fa(0), 32'h40400000);
      wr(A_CTRL, 32'h20000);
      wr(fa(0), 32'h3ff00000);
      wr(fa(1), 32'h0);
      wr(fa(2), 32'h40000000);
      wr(fa(3), 32'h0);
      op(16'hf020, LAT_ADD_D);
      rd(fa(0), 32'h40080000);
      rd(fa(1), 32'h0);
      // Frozen cycles stretch the add; a write while busy is refused
      wr(A_CMD, 32'h0000f020);
      ce <= 1'b0;
      repeat (3) @(posedge pclk);
      ce <= 1'b1;
      wr(fa(1), 32'h0000ffff);
      chk("busy write err", {31'h0, e}, 32'h1);
      repeat (2) @(posedge pclk);
      #1;
      chk("frozen busy", {31'h0, busy}, 32'h1);
      @(posedge pclk);
      #1;
      chk("frozen done", {31'h0, busy}, 32'h0);
      rd(fa(0), 32'h40140000);
      rd(fa(1), 32'h0);
      op(16'hf025, LAT_GT);
      chk("t_bit double gt", {31'h0, t_bit}, 32'h1);
      op(16'hf204, LAT_EQ);
      chk("t_bit double eq", {31'h0, t_bit}, 32'h0);
      // Stale inexact cause must be wiped by the add
      wr(A_CTRL, 32'h400);
      wr(fa(4), 32'h3f800000);
      wr(fa(5), 32'h7fc00000);
      op(16'hf450, LAT_ADD_S);
      rd(fa(4), 32'h7fbfffff);
      rd(A_CTRL, 32'h4010);
      wr(A_CTRL, 32'h0);
      wr(fa(6), 32'h7f800001);
      wr(fa(7), 32'h3f800000);
      op(16'hf760, LAT_ADD_S);
      u_faacu_host.xfer(1'b0, fa(7), 32'h0, q, e);
      chk("quiet nan", {31'h0, q[30:22] == 9'h1fe && q[21:0] != 0}, 32'h1);
      wr(A_CTRL, 32'h0);
      wr(fa(8), 32'h00000001);
      wr(fa(9), 32'h3f800000);
      op(16'hf980, LAT_ADD_S);
      rd(fa(9), 32'h3f800000);
      rd(A_CTRL, 32'h8000);
      wr(A_CTRL, 32'h10000);
      op(16'hf980, LAT_ADD_S);
      rd(fa(9), 32'h3f800000);
      rd(A_CTRL, 32'h10000);
      wr(A_CTRL, 32'h0);
      wr(fa(10), 32'h80000000);
      wr(fa(11), 32'h0);
      op(16'hfab0, LAT_ADD_S);
      rd(fa(10), 32'h0);
      wr(A_CTRL, 32'h20);
      wr(A_ICLR, 32'h7);
      wr(fa(12), 32'h3f800000);
      wr(fa(13), 32'h40000000);
      op(16'hfcd0, LAT_ADD_S);
      rd(fa(12), 32'h3f800000);
      rd(A_IST, 32'h3);
      wr(A_CTRL, 32'h0);
      cmp(32'h3f800000, 32'h3f800000, 1'b0, 1'b1);
      cmp(32'h40000000, 32'h3f800000, 1'b0, 1'b0);
      cmp(32'h40000000, 32'h3f800000, 1'b1, 1'b1);
      cmp(32'h3f800000, 32'h40000000, 1'b1, 1'b0);
      cmp(32'h80000000, 32'h00000000, 1'b0, 1'b1);
      cmp(32'h7f800001, 32'h7f800001, 1'b0, 1'b0);
      cmp(32'h7f800000, 32'h7f800000, 1'b0, 1'b1);
      cmp(32'h7f800001, 32'h3f800000, 1'b1, 1'b0);
      cmp(32'h7f800000, 32'h3f800000, 1'b1, 1'b1);
      cmp(32'h7fc00000, 32'h7fc00000, 1'b0, 1'b0);
      rd(A_CTRL, 32'h4010);
      wrap_up();
   end
endmodule
